// File: core/scs_sequencer.sv
// Purpose : Scan compare sequencer with APB registers and measurement FIFO
// Assumes : Measurements arrive as APB writes to the measurement register
// Notes   : Trigger pin is asynchronous and is synchronised before use
`timescale 1ns/10ps

// ------------------------------------------------------------
// Measurement FIFO
// ------------------------------------------------------------
module scs_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = scs_pkg::FIFO_DEPTH
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [W-1:0]               in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [W-1:0]                    out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]              mem [DEPTH];
	logic [AW-1:0]             wr_ptr_ff;
	logic [AW-1:0]             rd_ptr_ff;
	logic [$clog2(DEPTH+1)-1:0] cnt_ff;
	logic                      push;
	logic                      pop;

	assign in_ready  = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_ff];
	assign level     = cnt_ff;

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + 1'b1;
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

endmodule : scs_fifo

// ------------------------------------------------------------
// Sequencer top
// ------------------------------------------------------------
module scs_sequencer #(
	parameter int CYC_PER_MS = scs_pkg::CYC_PER_MS,
	parameter int FIFO_DEPTH = scs_pkg::FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        trigger_pin,
	output logic             relay_out,
	output logic             grade_pass,
	output logic             under_limit,
	output logic             over_limit,
	output logic             group_clk,
	output logic             scan_done_pulse
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                mode_pct_ff;
	logic                edge_fall_ff;
	logic                soft_trig_ff;
	logic [6:0]          chan_cnt_ff;
	logic [14:0]         delay_ms_ff;
	logic signed [31:0]  ref_ff;
	logic signed [31:0]  upper_ff;
	logic signed [31:0]  lower_ff;
	logic [31:0]         prdata_ff;
	logic                pslverr_ff;
	logic [2:0]          trig_sync_ff;
	logic                trig_edge;
	logic                start;
	scs_pkg::scs_state_t state_ff;
	scs_pkg::scs_state_t nxt_state;
	logic [6:0]          chan_idx_ff;
	logic [31:0]         cyc_cnt_ff;
	logic [14:0]         ms_cnt_ff;
	logic                pause_done;
	logic                last_chan;
	logic                relay_ff;
	logic                pass_ff;
	logic                under_ff;
	logic                over_ff;
	logic                group_clk_ff;
	logic                done_ff;
	logic                acc;
	logic                wr_acc;
	logic                mapped;
	logic                meas_wr;
	logic                fifo_in_ready;
	logic [31:0]         fifo_data;
	logic                fifo_valid;
	logic                fifo_pop;
	logic [LW-1:0]       fifo_level;
	scs_pkg::scs_grade_t grade;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [14:0] clamp15(input logic [31:0] v,
		input logic [14:0] lo, input logic [14:0] hi);
		if (v < {17'h0_0000, lo}) begin
			clamp15 = lo;
		end else if (v > {17'h0_0000, hi}) begin
			clamp15 = hi;
		end else begin
			clamp15 = v[14:0];
		end
	endfunction : clamp15

	function automatic scs_pkg::scs_grade_t grade_of(input logic pct,
		input logic signed [31:0] meas, input logic signed [31:0] refv,
		input logic signed [31:0] hi, input logic signed [31:0] lo);
		logic signed [63:0] val;
		val = 64'sh0;
		if (pct) begin
			if (refv == 32'sh0) begin
				val = 64'sh7FFF_FFFF_FFFF_FFFF;
			end else begin
				val = ((64'(meas) - 64'(refv)) * 64'sd100) / 64'(refv);
			end
		end else begin
			val = 64'(meas);
		end
		if (val > 64'(hi)) begin
			grade_of = scs_pkg::GR_OVER;
		end else if (val < 64'(lo)) begin
			grade_of = scs_pkg::GR_UNDER;
		end else begin
			grade_of = scs_pkg::GR_PASS;
		end
	endfunction : grade_of

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Measurement writes stall while the FIFO is full, so no sample is lost
	assign acc     = psel && penable;
	assign meas_wr = acc && pwrite && (paddr == scs_pkg::OFS_MEAS);
	assign pready  = !meas_wr || fifo_in_ready;
	assign wr_acc  = acc && pwrite && pready;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	always_comb begin
		case (paddr)
			scs_pkg::OFS_CTRL,
			scs_pkg::OFS_CHAN,
			scs_pkg::OFS_DELAY,
			scs_pkg::OFS_REF,
			scs_pkg::OFS_UPPER,
			scs_pkg::OFS_LOWER,
			scs_pkg::OFS_MEAS,
			scs_pkg::OFS_STATUS: mapped = 1'b1;
			default:             mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_pct_ff  <= 1'b0;
			edge_fall_ff <= 1'b0;
			chan_cnt_ff  <= scs_pkg::RST_CHAN;
			delay_ms_ff  <= scs_pkg::RST_DELAY_MS;
			ref_ff       <= scs_pkg::RST_WORD;
			upper_ff     <= scs_pkg::RST_WORD;
			lower_ff     <= scs_pkg::RST_WORD;
		end else if (wr_acc) begin
			case (paddr)
				scs_pkg::OFS_CTRL: begin
					mode_pct_ff  <= pwdata[scs_pkg::CTRL_MODE_BIT];
					edge_fall_ff <= pwdata[scs_pkg::CTRL_EDGE_BIT];
				end
				scs_pkg::OFS_CHAN: begin
					chan_cnt_ff <= 7'(clamp15(pwdata, {8'h00, scs_pkg::CHAN_MIN},
						{8'h00, scs_pkg::CHAN_MAX}));
				end
				scs_pkg::OFS_DELAY: begin
					delay_ms_ff <= clamp15(pwdata, scs_pkg::DELAY_MIN_MS,
						scs_pkg::DELAY_MAX_MS);
				end
				scs_pkg::OFS_REF:   ref_ff   <= pwdata;
				scs_pkg::OFS_UPPER: upper_ff <= pwdata;
				scs_pkg::OFS_LOWER: lower_ff <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// Software trigger stands in for the front-panel key
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_trig_ff <= 1'b0;
		end else begin
			soft_trig_ff <= wr_acc && (paddr == scs_pkg::OFS_CTRL)
				&& pwdata[scs_pkg::CTRL_TRIG_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= scs_pkg::RST_WORD;
			pslverr_ff <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_ff <= !mapped;
			case (paddr)
				scs_pkg::OFS_CTRL: begin
					prdata_ff <= {30'h0000_0000, edge_fall_ff, mode_pct_ff};
				end
				scs_pkg::OFS_CHAN:  prdata_ff <= {25'h000_0000, chan_cnt_ff};
				scs_pkg::OFS_DELAY: prdata_ff <= {17'h0_0000, delay_ms_ff};
				scs_pkg::OFS_REF:   prdata_ff <= ref_ff;
				scs_pkg::OFS_UPPER: prdata_ff <= upper_ff;
				scs_pkg::OFS_LOWER: prdata_ff <= lower_ff;
				scs_pkg::OFS_STATUS: begin
					prdata_ff <= '0;
					prdata_ff[scs_pkg::STAT_BUSY_BIT] <= (state_ff != scs_pkg::ST_IDLE);
					prdata_ff[scs_pkg::STAT_CHAN_LSB +: 7] <= chan_idx_ff;
					prdata_ff[scs_pkg::STAT_LEVEL_LSB +: LW] <= fifo_level;
				end
				default: prdata_ff <= scs_pkg::RST_WORD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Measurement FIFO
	// ------------------------------------------------------------
	scs_fifo #(
		.W     (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_data   (pwdata),
		.in_valid  (meas_wr),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	// ------------------------------------------------------------
	// Trigger pin
	// ------------------------------------------------------------
	// Bits 0 and 1 synchronise; bit 2 is only the edge detector's history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sync_ff <= 3'h0;
		end else begin
			trig_sync_ff <= {trig_sync_ff[1:0], trigger_pin};
		end
	end

	assign trig_edge = edge_fall_ff ? (trig_sync_ff[2] && !trig_sync_ff[1])
		: (!trig_sync_ff[2] && trig_sync_ff[1]);
	assign start = (trig_edge || soft_trig_ff)
		&& (state_ff == scs_pkg::ST_IDLE);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	assign last_chan  = (chan_idx_ff + 7'h01 >= chan_cnt_ff)
		|| (chan_idx_ff + 7'h01 >= scs_pkg::CHAN_MAX);
	assign pause_done = (ms_cnt_ff + 15'h0001 >= delay_ms_ff)
		&& (cyc_cnt_ff == 32'(CYC_PER_MS - 1));
	assign fifo_pop   = (state_ff == scs_pkg::ST_FETCH) && fifo_valid;
	assign grade      = grade_of(mode_pct_ff, fifo_data, ref_ff, upper_ff, lower_ff);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			scs_pkg::ST_IDLE:   if (start) nxt_state = scs_pkg::ST_FETCH;
			scs_pkg::ST_FETCH:  if (fifo_valid) nxt_state = scs_pkg::ST_SHOW;
			scs_pkg::ST_SHOW:   nxt_state = scs_pkg::ST_CLOCK;
			scs_pkg::ST_CLOCK:  nxt_state = last_chan ? scs_pkg::ST_FINISH
				: scs_pkg::ST_PAUSE;
			scs_pkg::ST_PAUSE:  if (pause_done) nxt_state = scs_pkg::ST_FETCH;
			scs_pkg::ST_FINISH: nxt_state = scs_pkg::ST_IDLE;
			default:            nxt_state = scs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= scs_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_idx_ff <= 7'h00;
		end else if (start) begin
			chan_idx_ff <= 7'h00;
		end else if (state_ff == scs_pkg::ST_PAUSE && pause_done) begin
			chan_idx_ff <= chan_idx_ff + 7'h01;
		end
	end

	// Two counters keep the pause exact without a 31-bit multiply
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_cnt_ff <= 32'h0000_0000;
			ms_cnt_ff  <= 15'h0000;
		end else if (state_ff != scs_pkg::ST_PAUSE) begin
			cyc_cnt_ff <= 32'h0000_0000;
			ms_cnt_ff  <= 15'h0000;
		end else if (cyc_cnt_ff == 32'(CYC_PER_MS - 1)) begin
			cyc_cnt_ff <= 32'h0000_0000;
			ms_cnt_ff  <= ms_cnt_ff + 15'h0001;
		end else begin
			cyc_cnt_ff <= cyc_cnt_ff + 32'h0000_0001;
		end
	end

	// Result group latched on the pop, held through the clock pulse and pause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_ff <= 1'b0;
			pass_ff  <= 1'b0;
			under_ff <= 1'b0;
			over_ff  <= 1'b0;
		end else if (fifo_pop) begin
			relay_ff <= 1'b1;
			pass_ff  <= (grade == scs_pkg::GR_PASS);
			under_ff <= (grade == scs_pkg::GR_UNDER);
			over_ff  <= (grade == scs_pkg::GR_OVER);
		end else if (state_ff == scs_pkg::ST_FINISH || start) begin
			relay_ff <= 1'b0;
			pass_ff  <= 1'b0;
			under_ff <= 1'b0;
			over_ff  <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_clk_ff <= 1'b0;
			done_ff      <= 1'b0;
		end else begin
			group_clk_ff <= (state_ff == scs_pkg::ST_SHOW);
			done_ff      <= (state_ff == scs_pkg::ST_CLOCK) && last_chan;
		end
	end

	assign relay_out       = relay_ff;
	assign grade_pass      = pass_ff;
	assign under_limit     = under_ff;
	assign over_limit      = over_ff;
	assign group_clk       = group_clk_ff;
	assign scan_done_pulse = done_ff;

endmodule : scs_sequencer

// File: shared/scs_pkg.sv
// Purpose : Constants, encodings and register map of the scan compare sequencer
// Assumes : pclk at 50 MHz, APB register access with 32-bit data
// Notes   : Limits are signed integers in ohm units (fixed) or whole percent
//
// Operation
// - A scan starts on a trigger pin pulse or a software trigger key.
// - External trigger edge is selectable rising or falling; only that edge starts.
// - Channels are stepped in order, at most 100, each graded against the limits.
// - Channel count setting holds 1 to 100 inclusive.
// - A programmable pause of 400 ms to 30000 ms separates channel measurements.
// - One high group clock pulse when a channel's relay and grades become valid.
// - At most 100 output groups, each with its own clock pulse, per scan.
// - After the last output group, one high pulse on the end-of-scan strobe.
// - Over-limit output means the measurement is above the upper limit.
// - Under-limit output means the measurement is below the lower limit.
// - Pass output means the measurement lies within both limits.
// - A relay control output is driven as part of each channel's group.
// - Between limits passes, below lower is under, above upper is over.
// - Fixed-limit mode compares the measurement directly with absolute limits.
// - Percent mode compares (meas - ref) / ref in percent against the limits.
// - Results are presented per channel and stop once the scan completes.

package scs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CHAN   = 8'h04;
	localparam logic [7:0] OFS_DELAY  = 8'h08;
	localparam logic [7:0] OFS_REF    = 8'h0C;
	localparam logic [7:0] OFS_UPPER  = 8'h10;
	localparam logic [7:0] OFS_LOWER  = 8'h14;
	localparam logic [7:0] OFS_MEAS   = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE_BIT  = 0;
	localparam int CTRL_EDGE_BIT  = 1;
	localparam int CTRL_TRIG_BIT  = 2;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_CHAN_LSB  = 8;
	localparam int STAT_LEVEL_LSB = 16;

	// ------------------------------------------------------------
	// Ranges and reset values
	// ------------------------------------------------------------
	localparam logic [6:0]  CHAN_MIN      = 7'h01;
	localparam logic [6:0]  CHAN_MAX      = 7'h64;
	localparam logic [14:0] DELAY_MIN_MS  = 15'h0190;
	localparam logic [14:0] DELAY_MAX_MS  = 15'h7530;
	localparam logic [6:0]  RST_CHAN      = 7'h64;
	localparam logic [14:0] RST_DELAY_MS  = 15'h0190;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_IN_NS      = 1000000;
	localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH    = 32;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_FETCH  = 3'b001,
		ST_SHOW   = 3'b010,
		ST_CLOCK  = 3'b011,
		ST_PAUSE  = 3'b100,
		ST_FINISH = 3'b101
	} scs_state_t;

	typedef enum logic [1:0] {
		GR_PASS  = 2'b00,
		GR_UNDER = 2'b01,
		GR_OVER  = 2'b10
	} scs_grade_t;

endpackage : scs_pkg

// File: tb/scs_handler_model.sv
// Purpose : Behavioural handler on the far side of the scan port
// Assumes : Grades are sampled on the group clock
// Notes   : Pin levels are held long enough for the two-flop synchroniser
`timescale 1ns/10ps

module scs_handler_model (
	input wire logic pclk,
	input wire logic relay_out,
	input wire logic grade_pass,
	input wire logic under_limit,
	input wire logic over_limit,
	input wire logic group_clk,
	input wire logic scan_done_pulse,
	output logic     trigger_pin
);
	logic [2:0] grades_q[$];
	int         n_done;
	int         n_norelay;

	initial begin
		trigger_pin = 1'b0;
		n_done = 0;
		n_norelay = 0;
	end

	always @(posedge pclk) begin
		if (group_clk === 1'b1) grades_q.push_back({over_limit, under_limit, grade_pass});
		if (scan_done_pulse === 1'b1) n_done++;
		if (group_clk === 1'b1 && relay_out !== 1'b1) n_norelay++;
	end

	task automatic drive_pin(input logic v);
		@(posedge pclk);
		trigger_pin <= v;
		repeat (6) @(posedge pclk);
	endtask : drive_pin
endmodule : scs_handler_model

// File: tb/scs_sequencer_chk.sv
// Purpose : Port-level assertions for the scan compare sequencer
// Assumes : Single pclk domain, presetn asynchronous active low
// Notes   : Pause length is only bounded from below, the full count is too long to unroll
`timescale 1ns/10ps

module scs_sequencer_chk #(
	parameter int CYC_PER_MS = 50000,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        relay_out,
	input wire logic        grade_pass,
	input wire logic        under_limit,
	input wire logic        over_limit,
	input wire logic        group_clk,
	input wire logic        scan_done_pulse
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Scan port
	// ------------------------------------------------------------
	property p_clk_pulse; group_clk |=> !group_clk; endproperty
	a_clk_pulse: assert property (p_clk_pulse) else $error("group clock too long");
	property p_relay_set; group_clk |-> relay_out && $past(relay_out); endproperty
	a_relay_set: assert property (p_relay_set) else $error("group not set up");
	property p_stable;
		group_clk |-> $stable({relay_out, grade_pass, under_limit, over_limit});
	endproperty
	a_stable: assert property (p_stable) else $error("group moved at clock");
	property p_onehot; relay_out |-> $onehot({grade_pass, under_limit, over_limit}); endproperty
	a_onehot: assert property (p_onehot) else $error("grades not one-hot");
	property p_gap; group_clk ##1 !scan_done_pulse |-> (!group_clk) [*8]; endproperty
	a_gap: assert property (p_gap) else $error("no pause between groups");
	property p_done_after; scan_done_pulse |-> $past(group_clk); endproperty
	a_done_after: assert property (p_done_after) else $error("strobe without group");
	property p_done_one; scan_done_pulse |=> !scan_done_pulse && !group_clk; endproperty
	a_done_one: assert property (p_done_one) else $error("strobe too long");
	property p_clear;
		scan_done_pulse |=> !relay_out && !grade_pass && !under_limit && !over_limit;
	endproperty
	a_clear: assert property (p_clear) else $error("outputs kept after scan");

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	property p_ready; psel && penable && !(pwrite && paddr == 8'h18) |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("slave stalled");
	property p_err; psel && penable && paddr > 8'h1C |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access accepted");
endmodule : scs_sequencer_chk

bind scs_sequencer scs_sequencer_chk #(.CYC_PER_MS(CYC_PER_MS), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .relay_out(relay_out),
	.grade_pass(grade_pass), .under_limit(under_limit), .over_limit(over_limit),
	.group_clk(group_clk), .scan_done_pulse(scan_done_pulse));

// File: tb/testbench.sv
// Purpose : Self-checking bench of the scan compare sequencer
// Assumes : Short millisecond count so a 400 ms pause lasts 1600 cycles
// Notes   : Grades are coded {over, under, pass}
`timescale 1ns/10ps

module testbench;
	localparam int         CPM = 4;
	localparam logic [2:0] GO  = 3'h4;
	localparam logic [2:0] GU  = 3'h2;
	localparam logic [2:0] GP  = 3'h1;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
	logic        trigger_pin, relay_out, grade_pass, under_limit, over_limit;
	logic        group_clk, scan_done_pulse;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors, num_checks, last_wait;
	logic [2:0]  pq[$];

	scs_sequencer #(.CYC_PER_MS(CPM)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_pin(trigger_pin), .relay_out(relay_out), .grade_pass(grade_pass),
		.under_limit(under_limit), .over_limit(over_limit), .group_clk(group_clk),
		.scan_done_pulse(scan_done_pulse));

	scs_handler_model handler_u (
		.pclk(pclk), .relay_out(relay_out), .grade_pass(grade_pass),
		.under_limit(under_limit), .over_limit(over_limit), .group_clk(group_clk),
		.scan_done_pulse(scan_done_pulse), .trigger_pin(trigger_pin));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; a wait that runs out ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 500) begin
			n++;
			@(posedge pclk);
		end
		if (n == 500) begin
			num_errors++;
			final_report();
		end
		rd = prdata;
		last_err = pslverr;
		last_wait = n;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_scan(input logic [2:0] exp_q[$]);
		int n0;
		int k;
		n0 = handler_u.n_done;
		k = 0;
		while (handler_u.n_done == n0 && k < 60000) begin
			k++;
			@(posedge pclk);
		end
		if (k == 60000) begin
			num_errors++;
			final_report();
		end
		chk("groups", handler_u.grades_q.size(), exp_q.size());
		chk("relay", handler_u.n_norelay, 32'h0);
		foreach (exp_q[i]) chk("grade", handler_u.grades_q[i], exp_q[i]);
		handler_u.grades_q.delete();
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("idle", rd[0], 1'b0);
	endtask : wait_scan

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, scs_pkg::OFS_CHAN, 32'h0);
		chk("chan_rst", rd, 32'h64);
		apb(1'b0, scs_pkg::OFS_DELAY, 32'h0);
		chk("delay_rst", rd, 32'h190);
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h0);
		apb(1'b0, scs_pkg::OFS_CHAN, 32'h0);
		chk("chan_lo", rd, 32'h1);
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h7F);
		apb(1'b0, scs_pkg::OFS_CHAN, 32'h0);
		chk("chan_hi", rd, 32'h64);
		apb(1'b1, scs_pkg::OFS_DELAY, 32'h7FFF);
		apb(1'b0, scs_pkg::OFS_DELAY, 32'h0);
		chk("delay_hi", rd, 32'h7530);
		apb(1'b1, scs_pkg::OFS_DELAY, 32'hA);
		apb(1'b0, scs_pkg::OFS_DELAY, 32'h0);
		chk("delay_lo", rd, 32'h190);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped_rd", rd, 32'h0);
		chk("unmapped_err", last_err, 1'b1);
		$display("t_regs done");
	endtask : t_regs

	// Reset in mid-run clears settings, FIFO and scan port
	task automatic t_reset();
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h5);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h64);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk("rst_port", {relay_out, grade_pass, under_limit, over_limit}, 32'h0);
		chk("rst_strobes", {group_clk, scan_done_pulse}, 32'h0);
		apb(1'b0, scs_pkg::OFS_CHAN, 32'h0);
		chk("chan_rst2", rd, 32'h64);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("fifo_rst", rd, 32'h0);
		$display("t_reset done");
	endtask : t_reset

	// Lower limit hit exactly, a second pulse arrives mid-scan
	task automatic t_fixed();
		apb(1'b1, scs_pkg::OFS_UPPER, 32'h6E);
		apb(1'b1, scs_pkg::OFS_LOWER, 32'h5A);
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h3);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h59);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h5A);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h6F);
		handler_u.drive_pin(1'b1);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("busy", rd[0], 1'b1);
		handler_u.drive_pin(1'b0);
		handler_u.drive_pin(1'b1);
		handler_u.drive_pin(1'b0);
		wait_scan('{GU, GP, GO});
		$display("t_fixed done");
	endtask : t_fixed

	task automatic t_pct();
		apb(1'b1, scs_pkg::OFS_REF, 32'h3E8);
		apb(1'b1, scs_pkg::OFS_UPPER, 32'h5);
		apb(1'b1, scs_pkg::OFS_LOWER, 32'hFFFF_FFFB);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h424);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h41A);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h3AC);
		apb(1'b1, scs_pkg::OFS_CTRL, 32'h5);
		apb(1'b0, scs_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		wait_scan('{GO, GP, GU});
		$display("t_pct done");
	endtask : t_pct

	task automatic t_edge();
		apb(1'b1, scs_pkg::OFS_CTRL, 32'h2);
		apb(1'b1, scs_pkg::OFS_UPPER, 32'h6E);
		apb(1'b1, scs_pkg::OFS_LOWER, 32'h5A);
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h1);
		apb(1'b1, scs_pkg::OFS_MEAS, 32'h32);
		handler_u.drive_pin(1'b1);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("no_start", rd[0], 1'b0);
		handler_u.drive_pin(1'b0);
		wait_scan('{GU});
		apb(1'b1, scs_pkg::OFS_CTRL, 32'h0);
		$display("t_edge done");
	endtask : t_edge

	// Fill until the write stalls, then drain to empty
	task automatic t_fifo();
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h2);
		repeat (32) apb(1'b1, scs_pkg::OFS_MEAS, 32'h64);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("full", rd[21:16], 6'h20);
		fork
			handler_u.drive_pin(1'b1);
			apb(1'b1, scs_pkg::OFS_MEAS, 32'h64);
		join
		chk("stalled", last_wait > 0, 1'b1);
		wait_scan('{GP, GP});
		handler_u.drive_pin(1'b0);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("level", rd[21:16], 6'h1F);
		apb(1'b1, scs_pkg::OFS_CHAN, 32'h1F);
		apb(1'b1, scs_pkg::OFS_CTRL, 32'h4);
		repeat (31) pq.push_back(GP);
		wait_scan(pq);
		apb(1'b0, scs_pkg::OFS_STATUS, 32'h0);
		chk("empty", rd[21:16], 6'h0);
		$display("t_fifo done");
	endtask : t_fifo

	initial begin
		num_errors = 0;
		num_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_reset();
		t_fixed();
		t_pct();
		t_edge();
		t_fifo();
		final_report();
	end
endmodule : testbench
